// File: verilog/osd_pkg.sv
// Summary of operation
// RL1 - Operand sizes: byte, word, longword, quadword
// RL2 - Data type and access come from opcode
// RL3 - Read fetches, write stores, modify both
// RL4 - Address access computes address, never operand
// RL5 - Register field uses register or pair
// RL6 - Branch specifier is displacement, no access
// RL7 - Mode field is two, four or eight bits
// RL8 - Literal value sits inside the specifier
// RL9 - Literal with non-read access faults
// RL10 - Indexed literal raises reserved mode fault
// RL11 - Mode five is register or register pair
// RL12 - Register mode with address access faults
// RL13 - Program counter in register mode undefined
// RL14 - Software avoids stack pointer register pairs
// RL15 - Word write keeps register upper half
// RL16 - Byte and word branch displacement forms
// RL17 - Sixteen registers, fifteen program counter
// RL18 - Zero to six specifiers per instruction
// RL19 - Mode upper nibble, register lower nibble
package osd_pkg;
  typedef enum logic [2:0] {
    OSD_DT_BYTE   = 3'h0,
    OSD_DT_WORD   = 3'h1,
    OSD_DT_LONG   = 3'h2,
    OSD_DT_QUAD   = 3'h3,
    OSD_DT_FLOAT  = 3'h4,
    OSD_DT_DOUBLE = 3'h5
  } osd_dtype_type;

  typedef enum logic [2:0] {
    OSD_AC_READ   = 3'h0,
    OSD_AC_WRITE  = 3'h1,
    OSD_AC_MODIFY = 3'h2,
    OSD_AC_ADDR   = 3'h3,
    OSD_AC_FIELD  = 3'h4,
    OSD_AC_BRANCH = 3'h5
  } osd_access_type;

  typedef enum logic [1:0] {
    OSD_EXT_NONE = 2'h0,
    OSD_EXT_DISP = 2'h1,
    OSD_EXT_IMM  = 2'h2,
    OSD_EXT_ABS  = 2'h3
  } osd_ext_type;

  typedef enum logic [1:0] {
    OSD_ST_IDLE  = 2'h0,
    OSD_ST_READ  = 2'h1,
    OSD_ST_WAIT  = 2'h3,
    OSD_ST_REPLY = 2'h2
  } osd_state_type;

  localparam int unsigned OSD_NUM_REGS = 16;
  localparam int unsigned OSD_REG_W    = 32;
  localparam int unsigned OSD_OPND_W   = 64;
  localparam int unsigned OSD_RIDX_W   = 4;
  localparam int unsigned OSD_LANES    = 4;
  localparam int unsigned OSD_BYTE_W   = 8;
  localparam int unsigned OSD_SPEC_W   = 16;
  localparam int unsigned OSD_LIT_W    = 6;
  localparam int unsigned OSD_CNT_W    = 3;

  localparam logic [3:0] OSD_PC_IDX          = 4'hF;
  localparam logic [3:0] OSD_SP_IDX          = 4'hE;
  localparam logic [1:0] OSD_LIT_TAG         = 2'h0;
  localparam logic [3:0] OSD_MODE_INDEX      = 4'h4;
  localparam logic [3:0] OSD_MODE_REG        = 4'h5;
  localparam logic [3:0] OSD_MODE_AUTOINC    = 4'h8;
  localparam logic [3:0] OSD_MODE_AUTOINC_DF = 4'h9;
  localparam logic [3:0] OSD_MODE_DISP_LO    = 4'hA;
  localparam logic [3:0] OSD_MBITS_LIT       = 4'h2;
  localparam logic [3:0] OSD_MBITS_GEN       = 4'h4;
  localparam logic [3:0] OSD_MBITS_EXT       = 4'h8;
  localparam logic [3:0] OSD_BE_BYTE         = 4'h1;
  localparam logic [3:0] OSD_BE_WORD         = 4'h3;
  localparam logic [3:0] OSD_BE_LONG         = 4'hF;
  localparam logic [3:0] OSD_SZ_BYTE         = 4'h1;
  localparam logic [3:0] OSD_SZ_WORD         = 4'h2;
  localparam logic [3:0] OSD_SZ_LONG         = 4'h4;
  localparam logic [3:0] OSD_SZ_QUAD         = 4'h8;
  localparam logic [2:0] OSD_MAX_SPECS       = 3'h6;

  function automatic logic osd_is_quad(input osd_dtype_type dt);
    return (dt == OSD_DT_QUAD) || (dt == OSD_DT_DOUBLE);
  endfunction

  function automatic logic [3:0] osd_size_bytes(input osd_dtype_type dt);
    logic [3:0] sz;
    unique case (dt)
      OSD_DT_BYTE:                sz = OSD_SZ_BYTE;
      OSD_DT_WORD:                sz = OSD_SZ_WORD;
      OSD_DT_LONG, OSD_DT_FLOAT:  sz = OSD_SZ_LONG;
      default:                    sz = OSD_SZ_QUAD;
    endcase
    return sz;
  endfunction

  function automatic logic [3:0] osd_lane_mask(input osd_dtype_type dt);
    logic [3:0] be;
    unique case (dt)
      OSD_DT_BYTE: be = OSD_BE_BYTE;
      OSD_DT_WORD: be = OSD_BE_WORD;
      default:     be = OSD_BE_LONG;
    endcase
    return be;
  endfunction
endpackage

// File: verilog/osd_rf_if.sv
interface osd_rf_if;
  import osd_pkg::*;
  logic                    rd_en;
  logic [OSD_RIDX_W-1:0]   rd_idx_lo;
  logic [OSD_RIDX_W-1:0]   rd_idx_hi;
  logic [OSD_REG_W-1:0]    rd_lo;
  logic [OSD_REG_W-1:0]    rd_hi;
  logic [OSD_LANES-1:0]    wr_lo_be;
  logic                    wr_hi_en;
  logic [OSD_RIDX_W-1:0]   wr_idx_lo;
  logic [OSD_RIDX_W-1:0]   wr_idx_hi;
  logic [OSD_OPND_W-1:0]   wr_data;

  modport ctrl (output rd_en, rd_idx_lo, rd_idx_hi, wr_lo_be, wr_hi_en, wr_idx_lo, wr_idx_hi, wr_data,
                input  rd_lo, rd_hi);
  modport mem  (input  rd_en, rd_idx_lo, rd_idx_hi, wr_lo_be, wr_hi_en, wr_idx_lo, wr_idx_hi, wr_data,
                output rd_lo, rd_hi);
endinterface

// File: verilog/osd_regfile.sv
module osd_regfile (
  input  logic   ref_clk_i,
  input  logic   arst_n_i,
  input  logic   ce_i,
  osd_rf_if.mem  rf
);
  import osd_pkg::*;

  logic [OSD_REG_W-1:0] regs_q [OSD_NUM_REGS];
  logic [OSD_REG_W-1:0] rd_lo_ff;
  logic [OSD_REG_W-1:0] rd_hi_ff;
  logic [OSD_REG_W-1:0] nxt_rd_lo;
  logic [OSD_REG_W-1:0] nxt_rd_hi;

  for (genvar g = 0; g < OSD_NUM_REGS; g++) begin : g_entry
    logic [OSD_REG_W-1:0] q_ff;
    logic [OSD_REG_W-1:0] nxt_q;
    always_comb begin
      nxt_q = q_ff;
      // Only enabled lanes change, so a word write leaves bits 31:16 alone
      for (int b = 0; b < OSD_LANES; b++) begin
        if (rf.wr_lo_be[b] && (rf.wr_idx_lo == OSD_RIDX_W'(g))) begin // RL15
          nxt_q[b*OSD_BYTE_W +: OSD_BYTE_W] = rf.wr_data[b*OSD_BYTE_W +: OSD_BYTE_W];
        end
        if (rf.wr_hi_en && (rf.wr_idx_hi == OSD_RIDX_W'(g))) begin // RL11
          nxt_q[b*OSD_BYTE_W +: OSD_BYTE_W] = rf.wr_data[OSD_REG_W + b*OSD_BYTE_W +: OSD_BYTE_W];
        end
      end
    end
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        q_ff <= '0;
      end else if (ce_i) begin
        q_ff <= nxt_q;
      end
    end
    assign regs_q[g] = q_ff;
  end

  always_comb begin
    nxt_rd_lo = rd_lo_ff;
    nxt_rd_hi = rd_hi_ff;
    if (rf.rd_en) begin
      nxt_rd_lo = regs_q[rf.rd_idx_lo];
      nxt_rd_hi = regs_q[rf.rd_idx_hi];
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_lo_ff <= '0;
      rd_hi_ff <= '0;
    end else if (ce_i) begin
      rd_lo_ff <= nxt_rd_lo;
      rd_hi_ff <= nxt_rd_hi;
    end
  end

  assign rf.rd_lo = rd_lo_ff;
  assign rf.rd_hi = rd_hi_ff;
endmodule

// File: verilog/osd_decoder.sv
module osd_decoder (
  input  logic                           ref_clk_i,
  input  logic                           arst_n_i,
  input  logic                           ce_i,
  input  logic                           insn_valid_i,
  input  logic [osd_pkg::OSD_CNT_W-1:0]  op_count_i,
  input  logic                           spec_valid_i,
  input  logic [osd_pkg::OSD_SPEC_W-1:0] spec_i,
  input  osd_pkg::osd_dtype_type         dtype_i,
  input  osd_pkg::osd_access_type        access_i,
  input  logic                           indexed_i,
  input  logic                           field_pair_i,
  input  logic                           wb_valid_i,
  input  logic [osd_pkg::OSD_OPND_W-1:0] wb_data_i,
  output logic                           ready_o,
  output logic                           done_o,
  output logic                           last_o,
  output logic                           fault_o,
  output logic                           wb_req_o,
  output logic [3:0]                     mode_o,
  output logic [3:0]                     mode_bits_o,
  output logic [osd_pkg::OSD_RIDX_W-1:0] reg_o,
  output logic                           pair_o,
  output logic [3:0]                     size_o,
  output logic                           fetch_o,
  output logic                           store_o,
  output logic                           addr_only_o,
  output osd_pkg::osd_ext_type           ext_o,
  output logic [osd_pkg::OSD_OPND_W-1:0] operand_o
);
  import osd_pkg::*;

  osd_rf_if rf ();

  osd_regfile u_regfile (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .ce_i      (ce_i),
    .rf        (rf.mem)
  );

  osd_state_type             state_ff;
  osd_state_type             nxt_state;
  logic [OSD_CNT_W-1:0]      remain_ff;
  logic [OSD_CNT_W-1:0]      nxt_remain;
  logic                      ready_ff, nxt_ready;
  logic                      done_ff, nxt_done;
  logic                      last_ff, nxt_last;
  logic                      fault_ff, nxt_fault;
  logic                      wb_req_ff, nxt_wb_req;
  logic [3:0]                mode_ff, nxt_mode;
  logic [3:0]                mbits_ff, nxt_mbits;
  logic [OSD_RIDX_W-1:0]     reg_ff, nxt_reg;
  logic                      pair_ff, nxt_pair;
  logic [3:0]                size_ff, nxt_size;
  logic                      fetch_ff, nxt_fetch;
  logic                      store_ff, nxt_store;
  logic                      aonly_ff, nxt_aonly;
  osd_ext_type               ext_ff, nxt_ext;
  logic [OSD_OPND_W-1:0]     opnd_ff, nxt_opnd;
  osd_dtype_type             dtype_ff, nxt_dtype;
  osd_access_type            access_ff, nxt_access;

  logic                      take;
  logic                      is_lit;
  logic                      is_reg;
  logic                      is_branch;
  logic                      dec_fault;
  logic [3:0]                dec_mode;
  logic [OSD_RIDX_W-1:0]     dec_reg;
  logic                      dec_pair;
  osd_ext_type               dec_ext;
  logic [OSD_OPND_W-1:0]     dec_opnd;

  // A specifier is only taken inside an announced instruction
  assign take = spec_valid_i && ready_ff && (remain_ff != '0); // RL18

  always_comb begin
    dec_mode  = spec_i[7:4]; // RL19
    dec_reg   = spec_i[3:0]; // RL19
    is_branch = (access_i == OSD_AC_BRANCH); // RL6
    is_lit    = !is_branch && (spec_i[7:6] == OSD_LIT_TAG); // RL7
    is_reg    = !is_branch && !is_lit && (dec_mode == OSD_MODE_REG); // RL11
    dec_pair  = is_reg && (osd_is_quad(dtype_i) || ((access_i == OSD_AC_FIELD) && field_pair_i)); // RL5
    dec_fault = 1'h0;
    if (is_lit && ((access_i != OSD_AC_READ) || indexed_i)) begin // RL9 RL10
      dec_fault = 1'h1;
    end
    // Register mode cannot be indexed either; same fault as address access
    if (is_reg && ((access_i == OSD_AC_ADDR) || indexed_i)) begin // RL12
      dec_fault = 1'h1;
    end
    dec_ext = OSD_EXT_NONE;
    if (!is_branch && !is_lit) begin // RL8
      if (dec_mode >= OSD_MODE_DISP_LO) begin
        dec_ext = OSD_EXT_DISP;
      end else if ((dec_mode == OSD_MODE_AUTOINC) && (dec_reg == OSD_PC_IDX)) begin // RL17
        dec_ext = OSD_EXT_IMM;
      end else if ((dec_mode == OSD_MODE_AUTOINC_DF) && (dec_reg == OSD_PC_IDX)) begin
        dec_ext = OSD_EXT_ABS;
      end
    end
    dec_opnd = '0;
    if (is_branch) begin // RL16
      if (dtype_i == OSD_DT_BYTE) begin
        dec_opnd = {{(OSD_OPND_W-OSD_BYTE_W){spec_i[OSD_BYTE_W-1]}}, spec_i[OSD_BYTE_W-1:0]};
      end else begin
        dec_opnd = {{(OSD_OPND_W-OSD_SPEC_W){spec_i[OSD_SPEC_W-1]}}, spec_i};
      end
    end else if (is_lit) begin // RL8
      dec_opnd = {{(OSD_OPND_W-OSD_LIT_W){1'h0}}, spec_i[OSD_LIT_W-1:0]};
    end
  end

  always_comb begin
    nxt_state  = state_ff;
    nxt_remain = remain_ff;
    nxt_last   = last_ff;
    nxt_fault  = fault_ff;
    nxt_mode   = mode_ff;
    nxt_mbits  = mbits_ff;
    nxt_reg    = reg_ff;
    nxt_pair   = pair_ff;
    nxt_size   = size_ff;
    nxt_fetch  = fetch_ff;
    nxt_store  = store_ff;
    nxt_aonly  = aonly_ff;
    nxt_ext    = ext_ff;
    nxt_opnd   = opnd_ff;
    nxt_dtype  = dtype_ff;
    nxt_access = access_ff;
    rf.rd_en     = 1'h0;
    rf.rd_idx_lo = spec_i[3:0];
    rf.rd_idx_hi = spec_i[3:0] + OSD_RIDX_W'(1); // RL11
    rf.wr_lo_be  = '0;
    rf.wr_hi_en  = 1'h0;
    rf.wr_idx_lo = reg_ff;
    rf.wr_idx_hi = reg_ff + OSD_RIDX_W'(1);
    rf.wr_data   = wb_data_i;
    unique case (state_ff)
      OSD_ST_IDLE: begin
        // Counts above six are refused; a zero count opens nothing
        if (insn_valid_i && ready_ff && (remain_ff == '0) && (op_count_i <= OSD_MAX_SPECS)) begin // RL18
          nxt_remain = op_count_i;
        end
        if (take) begin
          nxt_remain = remain_ff - OSD_CNT_W'(1);
          nxt_last   = (remain_ff == OSD_CNT_W'(1));
          nxt_fault  = dec_fault;
          nxt_mode   = dec_mode;
          nxt_mbits  = is_lit ? OSD_MBITS_LIT : ((dec_mode == 4'hF && dec_reg == 4'hF) ? OSD_MBITS_EXT
                                                                                       : OSD_MBITS_GEN); // RL7
          nxt_reg    = dec_reg;
          nxt_pair   = dec_pair;
          nxt_size   = osd_size_bytes(dtype_i); // RL1 RL2
          nxt_dtype  = dtype_i; // RL2
          nxt_access = access_i;
          nxt_ext    = dec_ext;
          nxt_opnd   = dec_opnd;
          nxt_fetch  = !dec_fault && ((access_i == OSD_AC_READ) || (access_i == OSD_AC_MODIFY)
                                      || (access_i == OSD_AC_FIELD && is_reg)); // RL3
          nxt_store  = !dec_fault && ((access_i == OSD_AC_WRITE) || (access_i == OSD_AC_MODIFY)); // RL3
          nxt_aonly  = !dec_fault && !is_reg && !is_lit && ((access_i == OSD_AC_ADDR)
                                      || (access_i == OSD_AC_FIELD)); // RL4 RL5
          nxt_state  = OSD_ST_REPLY;
          if (is_reg && !dec_fault) begin
            if (access_i == OSD_AC_WRITE) begin
              nxt_state = OSD_ST_WAIT;
            end else begin
              rf.rd_en  = 1'h1;
              nxt_state = OSD_ST_READ;
            end
          end
        end
      end
      OSD_ST_READ: begin
        // The program counter is read like any register; its value is undefined to software
        nxt_opnd  = pair_ff ? {rf.rd_hi, rf.rd_lo} : {{OSD_REG_W{1'h0}}, rf.rd_lo}; // RL11 RL13
        nxt_state = (access_ff == OSD_AC_MODIFY) ? OSD_ST_WAIT : OSD_ST_REPLY; // RL3
      end
      OSD_ST_WAIT: begin
        if (wb_valid_i) begin
          // Modify writes back even an unchanged value; no guard on the program counter
          rf.wr_lo_be = osd_lane_mask(dtype_ff); // RL15 RL3 RL13
          rf.wr_hi_en = pair_ff; // RL11
          nxt_state   = OSD_ST_REPLY;
        end
      end
      OSD_ST_REPLY: begin
        nxt_state = OSD_ST_IDLE;
      end
    endcase
    nxt_done   = (nxt_state == OSD_ST_REPLY) && (state_ff != OSD_ST_REPLY);
    nxt_ready  = (nxt_state == OSD_ST_IDLE);
    nxt_wb_req = (nxt_state == OSD_ST_WAIT);
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff  <= OSD_ST_IDLE;
      remain_ff <= '0;
      ready_ff  <= 1'h0;
      done_ff   <= 1'h0;
      last_ff   <= 1'h0;
      fault_ff  <= 1'h0;
      wb_req_ff <= 1'h0;
      mode_ff   <= '0;
      mbits_ff  <= '0;
      reg_ff    <= '0;
      pair_ff   <= 1'h0;
      size_ff   <= '0;
      fetch_ff  <= 1'h0;
      store_ff  <= 1'h0;
      aonly_ff  <= 1'h0;
      ext_ff    <= OSD_EXT_NONE;
      opnd_ff   <= '0;
      dtype_ff  <= OSD_DT_BYTE;
      access_ff <= OSD_AC_READ;
    end else if (ce_i) begin
      state_ff  <= nxt_state;
      remain_ff <= nxt_remain;
      ready_ff  <= nxt_ready;
      done_ff   <= nxt_done;
      last_ff   <= nxt_last;
      fault_ff  <= nxt_fault;
      wb_req_ff <= nxt_wb_req;
      mode_ff   <= nxt_mode;
      mbits_ff  <= nxt_mbits;
      reg_ff    <= nxt_reg;
      pair_ff   <= nxt_pair;
      size_ff   <= nxt_size;
      fetch_ff  <= nxt_fetch;
      store_ff  <= nxt_store;
      aonly_ff  <= nxt_aonly;
      ext_ff    <= nxt_ext;
      opnd_ff   <= nxt_opnd;
      dtype_ff  <= nxt_dtype;
      access_ff <= nxt_access;
    end
  end

  assign ready_o     = ready_ff;
  assign done_o      = done_ff;
  assign last_o      = last_ff;
  assign fault_o     = fault_ff;
  assign wb_req_o    = wb_req_ff;
  assign mode_o      = mode_ff;
  assign mode_bits_o = mbits_ff;
  assign reg_o       = reg_ff;
  assign pair_o      = pair_ff;
  assign size_o      = size_ff;
  assign fetch_o     = fetch_ff;
  assign store_o     = store_ff;
  assign addr_only_o = aonly_ff;
  assign ext_o       = ext_ff;
  assign operand_o   = opnd_ff;

  property p_lit_access;
    @(posedge ref_clk_i) disable iff (!arst_n_i || !ce_i)
    take && is_lit && (access_i != OSD_AC_READ) |=> done_o && fault_o && !fetch_o && !store_o;
  endproperty
  a_lit_access: assert property (p_lit_access) else $error("literal with non-read access not faulted"); // RL9

  property p_lit_index;
    @(posedge ref_clk_i) disable iff (!arst_n_i || !ce_i)
    take && is_lit && indexed_i |=> fault_o && done_o;
  endproperty
  a_lit_index: assert property (p_lit_index) else $error("indexed literal not faulted"); // RL10

  property p_lit_value;
    @(posedge ref_clk_i) disable iff (!arst_n_i || !ce_i)
    take && is_lit && (access_i == OSD_AC_READ) && !indexed_i
      |=> !fault_o && (operand_o[OSD_LIT_W-1:0] == $past(spec_i[OSD_LIT_W-1:0])) && (mode_bits_o == OSD_MBITS_LIT);
  endproperty
  a_lit_value: assert property (p_lit_value) else $error("literal value wrong"); // RL8

  property p_reg_addr;
    @(posedge ref_clk_i) disable iff (!arst_n_i || !ce_i)
    take && is_reg && (access_i == OSD_AC_ADDR) |=> fault_o && done_o && !wb_req_o;
  endproperty
  a_reg_addr: assert property (p_reg_addr) else $error("register mode address access not faulted"); // RL12

  property p_branch;
    @(posedge ref_clk_i) disable iff (!arst_n_i || !ce_i)
    take && is_branch && (dtype_i == OSD_DT_BYTE)
      |=> done_o && !fetch_o && !store_o && (operand_o[OSD_OPND_W-1:OSD_BYTE_W] == {(OSD_OPND_W-OSD_BYTE_W){$past(spec_i[7])}});
  endproperty
  a_branch: assert property (p_branch) else $error("byte branch displacement wrong"); // RL6

  property p_reg_read;
    @(posedge ref_clk_i) disable iff (!arst_n_i || !ce_i)
    take && is_reg && !dec_fault && (access_i == OSD_AC_READ) |=> !done_o ##1 done_o && fetch_o && !store_o;
  endproperty
  a_reg_read: assert property (p_reg_read) else $error("register read not answered in two cycles"); // RL11

  property p_modify_wb;
    @(posedge ref_clk_i) disable iff (!arst_n_i || !ce_i)
    (state_ff == OSD_ST_READ) && (access_ff == OSD_AC_MODIFY) |=> wb_req_o && !done_o;
  endproperty
  a_modify_wb: assert property (p_modify_wb) else $error("modify operand not written back"); // RL3

  property p_word_lanes;
    @(posedge ref_clk_i) disable iff (!arst_n_i || !ce_i)
    (state_ff == OSD_ST_WAIT) && wb_valid_i && (dtype_ff == OSD_DT_WORD) |-> (rf.wr_lo_be == OSD_BE_WORD) && !rf.wr_hi_en;
  endproperty
  a_word_lanes: assert property (p_word_lanes) else $error("word write touches upper half"); // RL15

  property p_pair_idx;
    @(posedge ref_clk_i) disable iff (!arst_n_i || !ce_i)
    take && dec_pair |=> pair_o && (reg_o == $past(spec_i[3:0]));
  endproperty
  a_pair_idx: assert property (p_pair_idx) else $error("register pair not flagged"); // RL5

  property p_count;
    @(posedge ref_clk_i) disable iff (!arst_n_i || !ce_i)
    spec_valid_i && ready_ff && (remain_ff == '0) |=> !done_o;
  endproperty
  a_count: assert property (p_count) else $error("specifier taken outside an instruction"); // RL18

  property p_size;
    @(posedge ref_clk_i) disable iff (!arst_n_i || !ce_i)
    take && (dtype_i == OSD_DT_DOUBLE) |=> (size_o == OSD_SZ_QUAD);
  endproperty
  a_size: assert property (p_size) else $error("double not sized as quadword"); // RL1
endmodule

// File: bench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import osd_pkg::*;
  logic                  ref_clk_i    = 1'b0;
  logic                  arst_n_i     = 1'b0;
  logic                  insn_valid_i = 1'b0;
  logic [OSD_CNT_W-1:0]  op_count_i   = '0;
  logic                  spec_valid_i = 1'b0;
  logic [OSD_SPEC_W-1:0] spec_i       = '0;
  osd_dtype_type         dtype_i      = OSD_DT_BYTE;
  osd_access_type        access_i     = OSD_AC_READ;
  logic                  indexed_i    = 1'b0;
  logic                  field_pair_i = 1'b0;
  logic                  ce_i         = 1'b1;
  logic                  wb_valid_i   = 1'b0;
  logic [OSD_OPND_W-1:0] wb_data_i    = '0;
  logic                  ready_o, done_o, last_o, fault_o, wb_req_o, pair_o, fetch_o, store_o, addr_only_o;
  logic [3:0]            mode_o, mode_bits_o, reg_o, size_o;
  osd_ext_type           ext_o;
  logic [OSD_OPND_W-1:0] operand_o, wbop;
  int                    fails = 0, checked = 0, lat;

  osd_decoder dut (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .insn_valid_i(insn_valid_i),
    .op_count_i(op_count_i), .spec_valid_i(spec_valid_i), .spec_i(spec_i), .dtype_i(dtype_i),
    .access_i(access_i), .indexed_i(indexed_i), .field_pair_i(field_pair_i), .wb_valid_i(wb_valid_i),
    .wb_data_i(wb_data_i), .ready_o(ready_o), .done_o(done_o), .last_o(last_o), .fault_o(fault_o),
    .wb_req_o(wb_req_o), .mode_o(mode_o), .mode_bits_o(mode_bits_o), .reg_o(reg_o), .pair_o(pair_o),
    .size_o(size_o), .fetch_o(fetch_o), .store_o(store_o), .addr_only_o(addr_only_o), .ext_o(ext_o),
    .operand_o(operand_o));

  always #12.5 ref_clk_i = ~ref_clk_i;

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // A hang counts as one mismatch and ends the run
  task automatic stall();
    check(64'h0, 64'h1);
    conclude();
  endtask

  task automatic res(input logic [3:0] e);
    check(64'({fault_o, fetch_o, store_o, addr_only_o}), 64'(e));
  endtask

  task automatic wait_ready();
    int k;
    k = 0;
    while (ready_o !== 1'b1) begin
      @(posedge ref_clk_i);
      k++;
      if (k > 20) stall();
    end
  endtask

  task automatic open_insn(input logic [2:0] n);
    wait_ready();
    insn_valid_i <= 1'b1;
    op_count_i   <= n;
    @(posedge ref_clk_i);
    insn_valid_i <= 1'b0;
  endtask

  // Offers one specifier, answers a write-back request once, returns at the edge that sees done
  task automatic put(input logic [15:0] s, input osd_dtype_type d, input osd_access_type a,
                     input logic ix, input logic [63:0] wd);
    logic sent;
    sent = 1'b0;
    wait_ready();
    spec_valid_i <= 1'b1;
    spec_i       <= s;
    dtype_i      <= d;
    access_i     <= a;
    indexed_i    <= ix;
    wb_data_i    <= wd;
    @(posedge ref_clk_i);
    spec_valid_i <= 1'b0;
    lat = 0;
    do begin
      @(posedge ref_clk_i);
      lat++;
      if (wb_valid_i === 1'b1) begin
        wb_valid_i <= 1'b0;
      end else if (wb_req_o === 1'b1 && !sent) begin
        wb_valid_i <= 1'b1;
        sent = 1'b1;
        wbop = operand_o;
      end
      if (lat > 20) stall();
    end while (done_o !== 1'b1);
  endtask

  task automatic t_literal();
    open_insn(3'h1);
    put(16'h002A, OSD_DT_LONG, OSD_AC_READ, 1'b0, '0);
    check(operand_o, 64'h2A);
    check(64'(mode_bits_o), 64'h2);
    check(64'(lat), 64'h1);
    res(4'h4);
    for (int i = 1; i < 5; i++) begin
      open_insn(3'h1);
      put(16'h002A, OSD_DT_LONG, osd_access_type'(i), 1'b0, '0);
      res(4'h8);
    end
    open_insn(3'h1);
    put(16'h002A, OSD_DT_LONG, OSD_AC_READ, 1'b1, '0);
    res(4'h8);
    $display("literal test done");
  endtask

  task automatic t_sizes();
    int sz [6] = '{1, 2, 4, 8, 4, 8};
    open_insn(3'h6);
    for (int i = 0; i < 6; i++) begin
      put(16'h0001, osd_dtype_type'(i), OSD_AC_READ, 1'b0, '0);
      check(64'(size_o), 64'(sz[i]));
      check(64'(last_o), 64'(i == 5));
    end
    $display("size test done");
  endtask

  task automatic t_register();
    open_insn(3'h1);
    put(16'h0052, OSD_DT_LONG, OSD_AC_WRITE, 1'b0, 64'hC0A0_5555);
    res(4'h2);
    open_insn(3'h1);
    put(16'h0052, OSD_DT_WORD, OSD_AC_WRITE, 1'b0, 64'h3412);
    open_insn(3'h1);
    put(16'h0052, OSD_DT_LONG, OSD_AC_READ, 1'b0, '0);
    check(operand_o, 64'hC0A0_3412);
    check(64'({mode_o, reg_o, mode_bits_o}), 64'h524);
    check(64'({pair_o, 4'(lat)}), 64'h2);
    res(4'h4);
    open_insn(3'h1);
    put(16'h0053, OSD_DT_QUAD, OSD_AC_WRITE, 1'b0, 64'h0BAD_F00D_1234_5678);
    open_insn(3'h1);
    put(16'h0053, OSD_DT_DOUBLE, OSD_AC_READ, 1'b0, '0);
    check(operand_o, 64'h0BAD_F00D_1234_5678);
    check(64'({pair_o, size_o}), 64'h18);
    field_pair_i <= 1'b1;
    open_insn(3'h1);
    put(16'h0053, OSD_DT_LONG, OSD_AC_FIELD, 1'b0, '0);
    check(operand_o, 64'h0BAD_F00D_1234_5678);
    field_pair_i <= 1'b0;
    open_insn(3'h1);
    put(16'h0054, OSD_DT_LONG, OSD_AC_READ, 1'b0, '0);
    check(operand_o, 64'h0BAD_F00D);
    open_insn(3'h1);
    put(16'h0053, OSD_DT_LONG, OSD_AC_ADDR, 1'b0, '0);
    res(4'h8);
    open_insn(3'h1);
    put(16'h0054, OSD_DT_LONG, OSD_AC_MODIFY, 1'b0, 64'h55);
    check(wbop, 64'h0BAD_F00D);
    res(4'h6);
    open_insn(3'h1);
    put(16'h0054, OSD_DT_LONG, OSD_AC_READ, 1'b0, '0);
    check(operand_o, 64'h55);
    $display("register test done");
  endtask

  task automatic t_address();
    logic [7:0] sp [4] = '{8'hC3, 8'h8F, 8'h9F, 8'hFF};
    logic [3:0] ex [4] = '{4'h1, 4'h2, 4'h3, 4'h1};
    logic [3:0] mb [4] = '{4'h4, 4'h4, 4'h4, 4'h8};
    open_insn(3'h1);
    put(16'h0066, OSD_DT_QUAD, OSD_AC_ADDR, 1'b0, '0);
    res(4'h1);
    for (int i = 0; i < 4; i++) begin
      open_insn(3'h1);
      put({8'h00, sp[i]}, OSD_DT_LONG, OSD_AC_READ, 1'b0, '0);
      check(64'(ext_o), 64'(ex[i]));
      check(64'(mode_bits_o), 64'(mb[i]));
    end
    $display("address test done");
  endtask

  task automatic t_branch();
    open_insn(3'h2);
    put(16'h12F0, OSD_DT_BYTE, OSD_AC_BRANCH, 1'b0, '0);
    check(operand_o, 64'hFFFF_FFFF_FFFF_FFF0);
    res(4'h0);
    put(16'h8001, OSD_DT_WORD, OSD_AC_BRANCH, 1'b0, '0);
    check(operand_o, 64'hFFFF_FFFF_FFFF_8001);
    $display("branch test done");
  endtask

  // A specifier offered while frozen must wait, and the open count must survive the stall
  task automatic t_freeze();
    int hits;
    hits = 0;
    open_insn(3'h1);
    ce_i         <= 1'b0;
    spec_valid_i <= 1'b1;
    spec_i       <= 16'h0015;
    repeat (4) begin
      @(posedge ref_clk_i);
      if (done_o !== 1'b0 || ready_o !== 1'b1) hits++;
    end
    check(64'(hits), 64'h0);
    ce_i <= 1'b1;
    put(16'h0015, OSD_DT_LONG, OSD_AC_READ, 1'b0, '0);
    check(operand_o, 64'h15);
    check(64'(lat), 64'h1);
    $display("clock enable test done");
  endtask

  task automatic t_refuse();
    int hits;
    hits = 0;
    open_insn(3'h7);
    spec_valid_i <= 1'b1;
    spec_i       <= 16'h002A;
    @(posedge ref_clk_i);
    spec_valid_i <= 1'b0;
    repeat (6) begin
      @(posedge ref_clk_i);
      if (done_o !== 1'b0) hits++;
    end
    check(64'(hits), 64'h0);
    $display("refusal test done");
  endtask

  initial begin
    repeat (3) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    t_literal();
    t_sizes();
    t_register();
    t_address();
    t_branch();
    t_freeze();
    t_refuse();
    conclude();
  end
endmodule
